/* src/line_chan_irq_status.sv */
// channel line-interface change status and cable attenuation registers
// assumes: APB master on pclk; condition inputs asynchronous
`timescale 1ns/100ps
`include "line_chan_defines.svh"

module line_chan_irq_status
  import line_chan_pkg::*;
#(
  parameter int ADDR_W  = 16,
  parameter int CHANNEL = 0,
  parameter int EQ_W    = `EQ_WIDTH
) (
  // clock and reset
  input  wire logic              pclk,
  input  wire logic              presetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic      [31:0]       prdata,
  output logic                   pslverr,
  // receive line conditions
  input  wire logic              loopcode_detect_state,
  input  wire logic              sigloss_state,
  input  wire logic              pattern_detect_state,
  input  wire logic [EQ_W-1:0]   eq_setting,
  // interrupt
  output logic                   irq
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  change_if chg ();

  localparam int SYNC_W = 3 + EQ_W;

  logic [SYNC_W-1:0] sync_level;
  logic [EQ_W-1:0]   att_s;
  logic [EQ_W-1:0]   att_prev_ff;
  logic [EQ_W-1:0]   att_ff;
  flag_vec_t         live_vec;
  logic [11:0]       idx;
  logic [11:0]       chan_off;
  logic              addr_ok;
  logic              setup;
  logic              access;
  logic              wr_en;
  reg_sel_t          reg_sel;
  apb_word_t         nxt_rdata;
  apb_word_t         prdata_ff;
  logic              err_ff;
  logic              nxt_err;
  flag_vec_t         en_ff;
  logic              rail_ff;
  logic              irq_ff;
  logic              nxt_irq;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // register index match for this channel
  function automatic logic hit(input logic [11:0] a,
                               input logic [11:0] r,
                               input logic [11:0] c);
    return a == (r | c);
  endfunction : hit

  // channel digit lands in the index
  assign chan_off = 12'(CHANNEL << `CHAN_SHIFT);
  assign idx      = paddr[13:2];
  assign addr_ok  = (paddr[1:0] == 2'h0) &&
                    (paddr[ADDR_W-1:14] == '0);

  // one-hot register select
  assign reg_sel =
    !addr_ok ? SEL_NONE :
    hit(idx, `IDX_IRQ_ENABLE, chan_off)    ? SEL_ENABLE :
    hit(idx, `IDX_LIVE_STATUS, chan_off)   ? SEL_LIVE :
    hit(idx, `IDX_CHANGE_STATUS, chan_off) ? SEL_CHANGE :
    hit(idx, `IDX_CABLE_ATT, chan_off)     ? SEL_CABLE :
    hit(idx, `IDX_LINE_CTRL, chan_off)     ? SEL_CTRL :
    SEL_NONE;

  // apb phases
  assign setup  = psel & ~penable;
  assign access = psel & penable;
  assign wr_en  = access & pwrite & (reg_sel != SEL_NONE);

  // ----------------------------------------------------------------
  // condition inputs
  // ----------------------------------------------------------------
  // conditions and attenuation cross into pclk
  cond_sync #(
    .W (SYNC_W)
  ) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({eq_setting, loopcode_detect_state,
                sigloss_state, pattern_detect_state}),
    .level_ff (sync_level)
  );

  // live vector at flag positions, bit 2 tied low
  assign live_vec = {sync_level[2], 1'b0,
                     sync_level[1], sync_level[0]};
  // attenuation bits settle one at a time; take the word only once it
  // holds still for a cycle, so a read never mixes two settings
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      att_prev_ff <= EQ_W'(`RST_CABLE_ATT);
      att_ff      <= EQ_W'(`RST_CABLE_ATT);
    end else begin
      att_prev_ff <= sync_level[SYNC_W-1:3];
      if (att_prev_ff == sync_level[SYNC_W-1:3]) begin
        att_ff <= att_prev_ff;
      end
    end
  end

  assign att_s    = att_ff;

  // ----------------------------------------------------------------
  // change flags
  // ----------------------------------------------------------------
  assign chg.live     = live_vec;
  assign chg.run      = rail_ff;
  // clearing read: access phase of a change status read
  assign chg.clr      = access & ~pwrite & (reg_sel == SEL_CHANGE);
  // clear only what the setup cycle captured
  assign chg.clr_mask = prdata_ff[3:0];

  change_flags u_flags (
    .pclk    (pclk),
    .presetn (presetn),
    .chg     (chg)
  );

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // data chosen in setup, presented through access
  always_comb begin
    nxt_rdata = 32'h0000_0000;
    unique case (reg_sel)
      SEL_NONE: begin
        nxt_rdata = 32'h0000_0000;
      end
      SEL_ENABLE: begin
        nxt_rdata[3:0] = rail_ff ? en_ff : 4'h0;
      end
      SEL_LIVE: begin
        nxt_rdata[3:0] = rail_ff ? live_vec : 4'h0;
      end
      SEL_CHANGE: begin
        nxt_rdata[3:0] = rail_ff ? chg.flags : 4'h0;
      end
      SEL_CABLE: begin
        nxt_rdata[EQ_W-1:0] = att_s;
      end
      SEL_CTRL: begin
        nxt_rdata[`BIT_SINGLE_RAIL] = rail_ff;
      end
    endcase
  end

  // unmapped or misaligned address answers with an error
  assign nxt_err = (reg_sel == SEL_NONE);

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // capture read data and error in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_ff <= 32'h0000_0000;
      err_ff    <= 1'b0;
    end else if (setup) begin
      prdata_ff <= pwrite ? 32'h0000_0000 : nxt_rdata;
      err_ff    <= nxt_err;
    end
  end

  // zero wait states
  assign pready  = 1'b1;
  assign prdata  = prdata_ff;
  assign pslverr = err_ff;

  // ----------------------------------------------------------------
  // writable registers
  // ----------------------------------------------------------------
  // interrupt enable, only the three live bits
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_ff <= `RST_IRQ_ENABLE;
    end else if (wr_en && reg_sel == SEL_ENABLE && rail_ff) begin
      en_ff <= pwdata[3:0] & `FLAG_MASK;
    end
  end

  // line mode control
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rail_ff <= `RST_SINGLE_RAIL;
    end else if (wr_en && reg_sel == SEL_CTRL) begin
      rail_ff <= pwdata[`BIT_SINGLE_RAIL];
    end
  end

  // ----------------------------------------------------------------
  // interrupt
  // ----------------------------------------------------------------
  // level while any enabled flag is pending in single-rail mode
  assign nxt_irq = rail_ff & (|(chg.flags & en_ff));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_ff <= 1'b0;
    end else begin
      irq_ff <= nxt_irq;
    end
  end

  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // loop-code change lands in bit 3 next cycle
  property p_loop_set;
    rail_ff && $changed(live_vec[`BIT_LOOPCODE])
      |=> chg.flags[`BIT_LOOPCODE];
  endproperty
  a_loop_set: assert property (p_loop_set)
    else $error("loop-code change not flagged");

  // signal loss change lands in bit 1 next cycle
  property p_loss_set;
    rail_ff && $changed(live_vec[`BIT_SIGLOSS])
      |=> chg.flags[`BIT_SIGLOSS];
  endproperty
  a_loss_set: assert property (p_loss_set)
    else $error("signal loss change not flagged");

  // pattern change lands in bit 0 next cycle
  property p_patt_set;
    rail_ff && $changed(live_vec[`BIT_PATTERN])
      |=> chg.flags[`BIT_PATTERN];
  endproperty
  a_patt_set: assert property (p_patt_set)
    else $error("pattern change not flagged");

  // reported flags are gone after a quiet clearing read
  property p_read_clr;
    chg.clr && (chg.set == 4'h0)
      |=> ((chg.flags & $past(chg.clr_mask)) == 4'h0);
  endproperty
  a_read_clr: assert property (p_read_clr)
    else $error("flag survived clearing read");

  // unused bit never rises, in flags or change status read data
  property p_unused;
    !chg.flags[`BIT_UNUSED] ##0
      (!$past(setup) || !prdata_ff[`BIT_UNUSED] ||
       $past(reg_sel) != SEL_CHANGE);
  endproperty
  a_unused: assert property (p_unused)
    else $error("unused status bit set");

  // outside single-rail no flag rises
  property p_rail_off;
    !rail_ff ##1 !$past(rail_ff)
      |-> ((chg.flags & ~$past(chg.flags)) == 4'h0);
  endproperty
  a_rail_off: assert property (p_rail_off)
    else $error("flag set outside single-rail");

  // live read returns the sampled conditions
  property p_live_rd;
    setup && !pwrite && reg_sel == SEL_LIVE && rail_ff
      |=> prdata_ff == {28'h0, $past(live_vec)};
  endproperty
  a_live_rd: assert property (p_live_rd)
    else $error("live status read wrong");

  // cable read returns attenuation with upper bits zero
  property p_cable_rd;
    setup && !pwrite && reg_sel == SEL_CABLE
      |=> prdata_ff == {{(32-EQ_W){1'b0}}, $past(att_s)};
  endproperty
  a_cable_rd: assert property (p_cable_rd)
    else $error("cable attenuation read wrong");

  // enabled transition reaches irq two cycles on
  property p_irq_raise;
    rail_ff && en_ff[`BIT_PATTERN] &&
      $changed(live_vec[`BIT_PATTERN])
      |-> ##2 (irq || !en_ff[`BIT_PATTERN] || !rail_ff);
  endproperty
  a_irq_raise: assert property (p_irq_raise)
    else $error("enabled change raised no interrupt");

  // change during the clearing read is kept
  property p_keep;
    chg.clr && chg.set[`BIT_SIGLOSS]
      |=> chg.flags[`BIT_SIGLOSS];
  endproperty
  a_keep: assert property (p_keep)
    else $error("change lost at clearing read");

  // a flag holds until a clearing read reports it
  property p_flag_hold;
    chg.flags[`BIT_SIGLOSS] && !(chg.clr && chg.clr_mask[`BIT_SIGLOSS])
      |=> chg.flags[`BIT_SIGLOSS];
  endproperty
  a_flag_hold: assert property (p_flag_hold)
    else $error("flag lost without clearing read");

  // no interrupt outside single-rail
  property p_irq_off;
    !rail_ff |=> !irq;
  endproperty
  a_irq_off: assert property (p_irq_off)
    else $error("interrupt raised outside single-rail");

  // enable register frozen outside single-rail
  property p_en_locked;
    !rail_ff |=> $stable(en_ff);
  endproperty
  a_en_locked: assert property (p_en_locked)
    else $error("enable changed outside single-rail");

endmodule : line_chan_irq_status

/* src/line_chan_defines.svh */
// register offsets, field positions, reset values and timing counts
// assumes: included by bare name from every file that needs a figure
`ifndef LINE_CHAN_DEFINES_SVH
`define LINE_CHAN_DEFINES_SVH

// ----------------------------------------------------------------
// register indices (byte address = 4 * index), channel 0
// ----------------------------------------------------------------
`define IDX_IRQ_ENABLE     12'hF04
`define IDX_LIVE_STATUS    12'hF05
`define IDX_CHANGE_STATUS  12'hF06
`define IDX_CABLE_ATT      12'hF07
`define IDX_LINE_CTRL      12'hF0F
`define CHAN_SHIFT         4

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define BIT_LOOPCODE       3
`define BIT_UNUSED         2
`define BIT_SIGLOSS        1
`define BIT_PATTERN        0
`define BIT_SINGLE_RAIL    0
`define FLAG_MASK          4'hB
`define EQ_WIDTH           6

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define RST_IRQ_ENABLE     4'h0
`define RST_FLAGS          4'h0
`define RST_LIVE           4'h0
`define RST_SINGLE_RAIL    1'b1
`define RST_CABLE_ATT      6'h00

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define SYNC_STAGES        3

`endif

/* src/line_chan_pkg.sv */
// types shared by the channel status register bank
// assumes: nothing outside itself
package line_chan_pkg;

  // ----------------------------------------------------------------
  // register select, one-hot
  // ----------------------------------------------------------------
  typedef enum logic [5:0] {
    SEL_NONE   = 6'b000001,
    SEL_ENABLE = 6'b000010,
    SEL_LIVE   = 6'b000100,
    SEL_CHANGE = 6'b001000,
    SEL_CABLE  = 6'b010000,
    SEL_CTRL   = 6'b100000
  } reg_sel_t;

  typedef logic [3:0]  flag_vec_t;
  typedef logic [31:0] apb_word_t;

endpackage : line_chan_pkg

/* src/change_if.sv */
// carrier between the register bank and its change-flag keeper
// assumes: both ends run on pclk
`timescale 1ns/100ps

interface change_if;
  import line_chan_pkg::*;

  flag_vec_t live;      // synchronised present conditions
  flag_vec_t set;       // change seen this cycle
  flag_vec_t clr_mask;  // bits reported by the read now ending
  flag_vec_t flags;     // sticky change flags
  logic      run;       // single-rail mode
  logic      clr;       // clearing read in its access cycle

  modport bank (output live, clr_mask, run, clr, input set, flags);
  modport keeper (input live, clr_mask, run, clr, output set, flags);
endinterface : change_if

/* src/cond_sync.sv */
// three-stage synchroniser for condition levels from the line side
// assumes: inputs asynchronous to pclk; output updates on agreement
`timescale 1ns/100ps
`include "line_chan_defines.svh"

module cond_sync #(
  parameter int W = 4
) (
  // clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // levels
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] level_ff
);

  // ----------------------------------------------------------------
  // one chain per bit
  // ----------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [`SYNC_STAGES-1:0] chain_ff;

      // shift in; stage 0 feeds only stage 1
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          chain_ff <= '0;
        end else begin
          chain_ff <= {chain_ff[`SYNC_STAGES-2:0], async_in[i]};
        end
      end

      // accept a change once stages two and three agree
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          level_ff[i] <= 1'b0;
        end else if (chain_ff[1] == chain_ff[2]) begin
          level_ff[i] <= chain_ff[2];
        end
      end
    end
  endgenerate

endmodule : cond_sync

/* src/change_flags.sv */
// sticky change-of-condition flags, cleared by a host read
// assumes: live is already in the pclk domain
`timescale 1ns/100ps
`include "line_chan_defines.svh"

module change_flags
  import line_chan_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // bank side
  change_if.keeper chg
);

  flag_vec_t prev_ff;
  flag_vec_t flags_ff;
  flag_vec_t nxt_flags;
  flag_vec_t clr_bits;

  // ----------------------------------------------------------------
  // change detection
  // ----------------------------------------------------------------
  // any transition of a live bit while single-rail
  assign chg.set   = (chg.live ^ prev_ff) & `FLAG_MASK &
                     {4{chg.run}};
  // only bits the host actually saw are cleared
  assign clr_bits  = chg.clr ? chg.clr_mask : 4'h0;
  // set wins over clear; unused bit stays low
  assign nxt_flags = ((flags_ff & ~clr_bits) | chg.set)
                     & `FLAG_MASK;
  assign chg.flags = flags_ff;

  // previous live value tracks always
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prev_ff <= `RST_LIVE;
    end else begin
      prev_ff <= chg.live;
    end
  end

  // sticky flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flags_ff <= `RST_FLAGS;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

endmodule : change_flags

/* sim/tb_line_chan_irq_status.sv */
// self-checking bench for the channel change status and cable registers
// assumes: design sources and line_chan_pkg compiled first
`timescale 1ns/100ps
`include "line_chan_defines.svh"

module tb_line_chan_irq_status;
  import line_chan_pkg::*;

  // ----------------------------------------------------------------
  // addresses and table of ordinary cases
  // ----------------------------------------------------------------
  localparam logic [15:0] A_EN   = 16'({`IDX_IRQ_ENABLE, 2'b00});
  localparam logic [15:0] A_LIVE = 16'({`IDX_LIVE_STATUS, 2'b00});
  localparam logic [15:0] A_CHG  = 16'({`IDX_CHANGE_STATUS, 2'b00});
  localparam logic [15:0] A_CAB  = 16'({`IDX_CABLE_ATT, 2'b00});
  localparam logic [15:0] A_CTRL = 16'({`IDX_LINE_CTRL, 2'b00});

  typedef struct packed {
    logic [3:0] cond;
    logic [5:0] eq;
    logic [3:0] live;
    logic [3:0] chg;
  } row_t;

  // conditions and equalizer in, live and change flags expected
  row_t rows [6] = '{
    '{4'h8, 6'h00, 4'h8, 4'h8},
    '{4'hA, 6'h3F, 4'hA, 4'h2},
    '{4'h3, 6'h2A, 4'h3, 4'h9},
    '{4'h0, 6'h15, 4'h0, 4'h3},
    '{4'hB, 6'h01, 4'hB, 4'hB},
    '{4'h0, 6'h20, 4'h0, 4'hB}
  };
  int bits [3] = '{0, 1, 3};

  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [15:0] paddr;
  apb_word_t   pwdata;
  apb_word_t   prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic [3:0]  cond;
  logic [5:0]  eq;
  apb_word_t   rd;
  logic        er;
  int          fails;
  int          comparisons;
  int          hits;

  // clock, 5 ns period
  initial pclk = 1'b0;
  always #2.5 pclk = ~pclk;

  line_chan_irq_status u_line_chan_irq_status (
    .pclk                  (pclk),
    .presetn               (presetn),
    .psel                  (psel),
    .penable               (penable),
    .pwrite                (pwrite),
    .paddr                 (paddr),
    .pwdata                (pwdata),
    .pready                (pready),
    .prdata                (prdata),
    .pslverr               (pslverr),
    .loopcode_detect_state (cond[3]),
    .sigloss_state         (cond[1]),
    .pattern_detect_state  (cond[0]),
    .eq_setting            (eq),
    .irq                   (irq)
  );

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic test_done;
    $display("comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : test_done

  task automatic chk(input apb_word_t got, input apb_word_t exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; keep leaves psel up for a back-to-back setup
  task automatic xfer(input logic wr, input logic [15:0] a,
                      input apb_word_t wd, input logic keep);
    int n;
    n = 0;
    if (!psel) psel <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      fails++;
      test_done;
    end
    rd = prdata;
    er = pslverr;
    penable <= 1'b0;
    if (!keep) begin
      psel <= 1'b0;
      @(posedge pclk);
    end
  endtask : xfer

  task automatic rd_chk(input logic [15:0] a, input apb_word_t exp);
    xfer(1'b0, a, 32'h0, 1'b0);
    chk(rd, exp);
  endtask : rd_chk

  task automatic wr(input logic [15:0] a, input apb_word_t d);
    xfer(1'b1, a, d, 1'b0);
  endtask : wr

  // synchroniser plus flag and irq stages, with margin
  task automatic settle;
    repeat (8) @(posedge pclk);
  endtask : settle

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h0;
    cond = 4'h0;
    eq = 6'h00;
    fails = 0;
    comparisons = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    // reset values
    rd_chk(A_EN, 32'h0);
    rd_chk(A_LIVE, 32'h0);
    rd_chk(A_CHG, 32'h0);
    rd_chk(A_CAB, 32'h0);
    rd_chk(A_CTRL, 32'h1);
    // table of condition and equalizer cases
    for (int i = 0; i < 6; i++) begin
      cond <= rows[i].cond;
      eq <= rows[i].eq;
      settle;
      rd_chk(A_LIVE, 32'(rows[i].live));
      rd_chk(A_CHG, 32'(rows[i].chg));
      rd_chk(A_CHG, 32'h0);
      rd_chk(A_CAB, 32'(rows[i].eq));
    end
    // each enabled change raises irq, the read drops it
    foreach (bits[k]) begin
      wr(A_EN, 32'h1 << bits[k]);
      cond[bits[k]] <= ~cond[bits[k]];
      settle;
      chk(32'(irq), 32'h1);
      rd_chk(A_CHG, 32'h1 << bits[k]);
      repeat (2) @(posedge pclk);
      chk(32'(irq), 32'h0);
    end
    cond <= 4'h0;
    settle;
    rd_chk(A_CHG, 32'hB);
    // masked change sets the flag but not irq
    wr(A_EN, 32'h1);
    cond[1] <= 1'b1;
    settle;
    chk(32'(irq), 32'h0);
    rd_chk(A_CHG, 32'h2);
    // single-rail off: live, flags and enable writes dead
    wr(A_CTRL, 32'h0);
    cond[3] <= 1'b1;
    settle;
    rd_chk(A_LIVE, 32'h0);
    rd_chk(A_CHG, 32'h0);
    chk(32'(irq), 32'h0);
    wr(A_EN, 32'hB);
    wr(A_CTRL, 32'h1);
    settle;
    xfer(1'b0, A_CHG, 32'h0, 1'b0);
    rd_chk(A_EN, 32'h1);
    rd_chk(A_LIVE, 32'hA);
    cond[3] <= 1'b0;
    settle;
    rd_chk(A_CHG, 32'h8);
    // unmapped read refused and leaves flags alone
    cond[0] <= 1'b1;
    settle;
    xfer(1'b0, A_CAB + 16'h0004, 32'h0, 1'b0);
    chk(32'(er), 32'h1);
    rd_chk(A_CHG, 32'h1);
    // cable register ignores writes
    wr(A_CAB, 32'hFF);
    chk(32'(er), 32'h0);
    rd_chk(A_CAB, 32'h20);
    // change racing back-to-back clearing reads is reported once
    hits = 0;
    cond[0] <= 1'b0;
    for (int k = 0; k < 8; k++) begin
      xfer(1'b0, A_CHG, 32'h0, k < 7);
      if (rd === 32'h1) hits++;
    end
    chk(32'(hits), 32'h1);
    // second reset in mid-run
    wr(A_EN, 32'hB);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(32'(irq), 32'h0);
    rd_chk(A_EN, 32'h0);
    rd_chk(A_CTRL, 32'h1);
    test_done;
  end

endmodule : tb_line_chan_irq_status
